/* File: slpseq_demo_ctr.sv */
/*
 * demonstration user logic: 8-bit counter, held while asleep, with entry and exit
 * snapshots; assumes the controller pulses each capture for one cycle
 */
`timescale 1ns/100ps
`default_nettype none

module slpseq_demo_ctr
   import slpseq_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // controller side
   slpseq_demo_if.demo dif
);

   logic frozen_ff;          // counter held while asleep
   slpseq_cnt_t cnt_ff;      // running count
   slpseq_cnt_t enter_ff;    // entry snapshot
   slpseq_cnt_t exit_ff;     // exit snapshot

   // freeze after the entry capture, release with the exit capture
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         frozen_ff <= 1'b0;
      end else if (dif.capture_enter) begin
         frozen_ff <= 1'b1;
      end else if (dif.capture_exit) begin
         frozen_ff <= 1'b0;
      end
   end

   // count only while not frozen, so both snapshots must agree
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff <= 8'h00;
      end else if (!frozen_ff && !dif.capture_enter) begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end

   // snapshots take the value that stands at the capture edge
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         enter_ff <= 8'h00;
         exit_ff <= 8'h00;
      end else begin
         if (dif.capture_enter) enter_ff <= cnt_ff;
         if (dif.capture_exit) exit_ff <= cnt_ff;
      end
   end

   assign dif.count = cnt_ff;
   assign dif.enter_snap = enter_ff;
   assign dif.exit_snap = exit_ff;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_enter_snap_value: assert property (dif.capture_enter |=> (enter_ff == $past(cnt_ff)) && (cnt_ff == $past(cnt_ff)))
      else $error("entry snapshot or freeze wrong");
   a_exit_resume: assert property (dif.capture_exit |=> exit_ff == $past(cnt_ff) ##1 cnt_ff == exit_ff + 8'h01)
      else $error("exit snapshot or resume wrong");
endmodule : slpseq_demo_ctr

`default_nettype wire

/* File: slpseq_demo_if.sv */
/*
 * carrier between the sequencer controller and its demonstration counter;
 * assumes both ends run on the same continuously running clock
 */
`timescale 1ns/100ps
`default_nettype none

interface slpseq_demo_if;
   import slpseq_pkg::*;
   logic capture_enter;      // one-cycle pulse: snapshot and freeze
   logic capture_exit;       // one-cycle pulse: snapshot and release
   slpseq_cnt_t count;       // running counter value
   slpseq_cnt_t enter_snap;  // value caught on the way into sleep
   slpseq_cnt_t exit_snap;   // value caught on the way out of sleep

   modport ctrl (output capture_enter, output capture_exit,
                 input count, input enter_snap, input exit_snap);
   modport demo (input capture_enter, input capture_exit,
                 output count, output enter_snap, output exit_snap);
endinterface : slpseq_demo_if

`default_nettype wire

/* File: slpseq_far_end.sv */
/*
 * far side model: sleep requester, the clock gate of net 0 and pulled-up pads;
 * assumes the bench changes want_sleep only at rising edges
 */
`timescale 1ns/100ps
`default_nettype none

module slpseq_far_end
   import slpseq_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // bench request
   input wire logic want_sleep,
   // sequencer outputs
   input wire slpseq_nets_t global_clock_net_en,
   input wire logic [3:0] gpio_pad_o,
   input wire logic [3:0] gpio_pad_oe,
   // toward the sequencer
   output logic sleep_req,
   // far-side observations
   output logic [3:0] pad_level,
   output logic [15:0] net_ticks
);
   // request forced low while reset holds the device in power-up
   assign sleep_req = resetn & want_sleep;

   // a released pad goes to the weak pull-up, never keeps its last value
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pad_level[i] = gpio_pad_oe[i] ? gpio_pad_o[i] : 1'b1;
      end
   end

   // gate of net 0: counts only the edges that would pass the gate
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         net_ticks <= 16'h0000;
      end else if (global_clock_net_en[0]) begin
         net_ticks <= net_ticks + 16'h0001;
      end
   end
endmodule : slpseq_far_end

`default_nettype wire

/* File: slpseq_pkg.sv */
/*
 * types shared by the sleep power sequencer files;
 * assumes slpseq_regs.svh is on the include path
 */
package slpseq_pkg;
`include "slpseq_regs.svh"

   // controller states; the four documented phases are split into steps
   typedef enum logic [2:0] {
      ST_AWAKE, ST_ENTER_BUF, ST_ENTER_CLK, ST_ENTER_GATE,
      ST_SLEEP, ST_EXIT_CLK, ST_EXIT_GATE, ST_EXIT_BUF
   } slpseq_state_e;

   typedef logic [`SLPSEQ_DLY_W-1:0] slpseq_dly_t;  // one delay field
   typedef logic [7:0] slpseq_cnt_t;                // demo counter value
   typedef logic [`SLPSEQ_NETS-1:0] slpseq_nets_t;  // clock gate enables
endpackage : slpseq_pkg

/* File: slpseq_regs.svh */
/*
 * register offsets, field positions, reset values and sequencing figures
 * of the sleep power sequencer; assumes nothing beyond a preprocessor
 */
`ifndef SLPSEQ_REGS_SVH
`define SLPSEQ_REGS_SVH

// wishbone byte addresses, one aligned 32-bit word each
`define SLPSEQ_ADR_DELAY 4'h0
`define SLPSEQ_ADR_STATUS 4'h4
`define SLPSEQ_ADR_COUNT 4'h8

// delay register: one 6-bit field in the low bits of each byte lane
`define SLPSEQ_DLY_W 6
`define SLPSEQ_DLY_LANES 4
`define SLPSEQ_IDX_BUF_OFF 0
`define SLPSEQ_IDX_CLK_OFF 1
`define SLPSEQ_IDX_CLK_ON 2
`define SLPSEQ_IDX_BUF_ON 3

// least delays in controller clock cycles; also the reset values
`define SLPSEQ_MIN_BUF_OFF 6'h01
`define SLPSEQ_MIN_CLK_OFF 6'h0b
`define SLPSEQ_MIN_CLK_ON 6'h01
`define SLPSEQ_MIN_BUF_ON 6'h28

// global clock net gating: sixteen enables in three groups of six, six and four
`define SLPSEQ_NETS 16
`define SLPSEQ_GATE_GROUP 6
`define SLPSEQ_GATE_LAST 2'h2

`endif

/* File: slpseq_top.sv */
/*
 * sleep power sequencer: steps the device into and out of sleep by gating
 * sixteen global clock net enables and one buffer drive enable, with four
 * programmable delays reached over a classic wishbone slave.
 * assumes sys_clk comes from an oscillator that never stops, that sleep_req
 * is synchronous to it, and that the clock gates and i/o buffers sit outside
 */
`timescale 1ns/100ps
`default_nettype none

module slpseq_top
   import slpseq_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // sleep requester
   input wire logic sleep_req,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // power control outputs
   output logic [15:0] global_clock_net_en,
   output logic buf_drive_en,
   output logic sleep_status,
   // demonstration outputs
   output logic [3:0] gpio_pad_o,
   output logic [3:0] gpio_pad_oe,
   output logic [7:0] cnt_value,
   output logic [7:0] cnt_enter_snap,
   output logic [7:0] cnt_exit_snap
);

   slpseq_state_e state_ff;                      // sequencer state
   slpseq_dly_t dly_cnt_ff;                      // cycles left in a wait
   logic [1:0] step_ff;                          // gate group being switched
   slpseq_dly_t dly_ff [`SLPSEQ_DLY_LANES];      // programmed delays
   slpseq_dly_t dly_eff [`SLPSEQ_DLY_LANES];     // delays in force
   slpseq_nets_t gate_en_ff;                     // clock gate enables
   logic buf_en_ff;                              // buffer drive enable
   logic status_ff;                              // sleep status
   logic [3:0] pad_ff;                           // demo pad data
   logic ack_ff;                                 // wishbone acknowledge
   logic [31:0] rd_data_ff;                      // registered read data
   logic bus_req;                                // new wishbone request
   logic [1:0] phase;                            // coarse state for software
   logic cnt_done;                               // current wait has elapsed
   logic gate_done;                              // last gate group switched
   logic [31:0] rd_mux;                          // read data before the flop

   slpseq_demo_if demo_if ();

   // demonstration user logic on the same free-running clock
   slpseq_demo_ctr u_demo (
      .sys_clk (sys_clk),
      .resetn (resetn),
      .dif (demo_if.demo)
   );

   // least delays, one per lane, in lane index order; kept as constants so
   // the asynchronous reset of the delay register loads no logic output
   localparam slpseq_dly_t DLY_MIN [`SLPSEQ_DLY_LANES] = '{
      `SLPSEQ_MIN_BUF_OFF, `SLPSEQ_MIN_CLK_OFF, `SLPSEQ_MIN_CLK_ON, `SLPSEQ_MIN_BUF_ON
   };

   // per-lane delay register and its clamp; a setting below the minimum
   // would break the buffer and gate timing, so it is raised to the floor
   // instead of being refused, and reads back as written
   for (genvar g = 0; g < `SLPSEQ_DLY_LANES; g++) begin : g_dly
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            dly_ff[g] <= DLY_MIN[g];
         end else if (ack_ff && wb_cyc_i && wb_stb_i && wb_we_i &&
                      wb_adr_i == `SLPSEQ_ADR_DELAY && wb_sel_i[g]) begin
            dly_ff[g] <= wb_dat_i[8*g +: `SLPSEQ_DLY_W];
         end
      end
      assign dly_eff[g] = (dly_ff[g] < DLY_MIN[g]) ? DLY_MIN[g] : dly_ff[g];
   end

   assign cnt_done = (dly_cnt_ff == 6'h00);
   assign gate_done = (step_ff == `SLPSEQ_GATE_LAST);

   // main sequencer; sleep_req is only looked at in the two resting states,
   // so a change during a sequence waits until that sequence is over.
   // this clock never stops, even with every global net gated off
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= ST_AWAKE;
         dly_cnt_ff <= 6'h00;
         step_ff <= 2'h0;
      end else begin
         unique case (state_ff)
            // resting awake until the request rises
            ST_AWAKE: begin
               if (sleep_req) begin
                  state_ff <= ST_ENTER_BUF;
                  dly_cnt_ff <= dly_eff[`SLPSEQ_IDX_BUF_OFF] - 6'h01;
               end
            end
            // wait out the buffer-off delay
            ST_ENTER_BUF: begin
               if (cnt_done) begin
                  state_ff <= ST_ENTER_CLK;
                  dly_cnt_ff <= dly_eff[`SLPSEQ_IDX_CLK_OFF] - 6'h01;
               end else begin
                  dly_cnt_ff <= dly_cnt_ff - 6'h01;
               end
            end
            // wait out the clock-off delay
            ST_ENTER_CLK: begin
               if (cnt_done) begin
                  state_ff <= ST_ENTER_GATE;
                  step_ff <= 2'h0;
               end else begin
                  dly_cnt_ff <= dly_cnt_ff - 6'h01;
               end
            end
            // clear one gate group per cycle, then rest
            ST_ENTER_GATE: begin
               if (gate_done) begin
                  state_ff <= ST_SLEEP;
                  step_ff <= 2'h0;
               end else begin
                  step_ff <= step_ff + 2'h1;
               end
            end
            // resting asleep while the request holds
            ST_SLEEP: begin
               if (!sleep_req) begin
                  state_ff <= ST_EXIT_CLK;
                  dly_cnt_ff <= dly_eff[`SLPSEQ_IDX_CLK_ON] - 6'h01;
               end
            end
            // wait out the clock-on delay
            ST_EXIT_CLK: begin
               if (cnt_done) begin
                  state_ff <= ST_EXIT_GATE;
                  step_ff <= 2'h0;
               end else begin
                  dly_cnt_ff <= dly_cnt_ff - 6'h01;
               end
            end
            // set one gate group per cycle, then start the buffer-on wait
            ST_EXIT_GATE: begin
               if (gate_done) begin
                  state_ff <= ST_EXIT_BUF;
                  step_ff <= 2'h0;
                  dly_cnt_ff <= dly_eff[`SLPSEQ_IDX_BUF_ON] - 6'h01;
               end else begin
                  step_ff <= step_ff + 2'h1;
               end
            end
            // wait out the buffer-on delay
            ST_EXIT_BUF: begin
               if (cnt_done) begin
                  state_ff <= ST_AWAKE;
               end else begin
                  dly_cnt_ff <= dly_cnt_ff - 6'h01;
               end
            end
         endcase
      end
   end

   // clock gate enables, active high: group k of up to six nets switches at step k,
   // so bit 0 goes first and bit 15 last, all within three cycles
   for (genvar i = 0; i < `SLPSEQ_NETS; i++) begin : g_gate
      localparam logic [1:0] GRP = 2'(i / `SLPSEQ_GATE_GROUP);
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            gate_en_ff[i] <= 1'b1;
         end else if (state_ff == ST_ENTER_GATE && step_ff >= GRP) begin
            gate_en_ff[i] <= 1'b0;
         end else if (state_ff == ST_EXIT_GATE && step_ff >= GRP) begin
            gate_en_ff[i] <= 1'b1;
         end
      end
   end
   assign global_clock_net_en = gate_en_ff;

   // buffer drive enable feeds the output enable of all four demo pads
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         buf_en_ff <= 1'b1;
      end else if (state_ff == ST_ENTER_BUF && cnt_done) begin
         buf_en_ff <= 1'b0;
      end else if (state_ff == ST_EXIT_BUF && cnt_done) begin
         buf_en_ff <= 1'b1;
      end
   end
   assign buf_drive_en = buf_en_ff;

   // sleep status rises with the request taken, falls only when fully awake
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         status_ff <= 1'b0;
      end else if (state_ff == ST_AWAKE && sleep_req) begin
         status_ff <= 1'b1;
      end else if (state_ff == ST_EXIT_BUF && cnt_done) begin
         status_ff <= 1'b0;
      end
   end
   assign sleep_status = status_ff;

   // capture pulses: entry on the last gate step, exit on the last buffer cycle
   assign demo_if.capture_enter = (state_ff == ST_ENTER_GATE) && gate_done;
   assign demo_if.capture_exit = (state_ff == ST_EXIT_BUF) && cnt_done;

   // demo pads show the counter's upper nibble; they float with the buffers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pad_ff <= 4'h0;
      end else begin
         pad_ff <= demo_if.count[7:4];
      end
   end
   assign gpio_pad_o = pad_ff;
   assign gpio_pad_oe = {4{buf_en_ff}};
   assign cnt_value = demo_if.count;
   assign cnt_enter_snap = demo_if.enter_snap;
   assign cnt_exit_snap = demo_if.exit_snap;

   // coarse phase for software: 0 awake, 1 entering, 2 sleep, 3 exiting
   always_comb begin
      unique case (state_ff)
         ST_AWAKE: phase = 2'h0;
         ST_ENTER_BUF, ST_ENTER_CLK, ST_ENTER_GATE: phase = 2'h1;
         ST_SLEEP: phase = 2'h2;
         ST_EXIT_CLK, ST_EXIT_GATE, ST_EXIT_BUF: phase = 2'h3;
      endcase
   end

   // wishbone: every access is answered one cycle later, unmapped reads zero
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;

   // read multiplexer; reserved bits read as zero
   always_comb begin
      unique case (wb_adr_i)
         `SLPSEQ_ADR_DELAY: rd_mux = {2'h0, dly_ff[3], 2'h0, dly_ff[2],
                                      2'h0, dly_ff[1], 2'h0, dly_ff[0]};
         `SLPSEQ_ADR_STATUS: rd_mux = {gate_en_ff, 12'h000, phase, buf_en_ff,
                                       status_ff};
         `SLPSEQ_ADR_COUNT: rd_mux = {8'h00, demo_if.exit_snap,
                                      demo_if.enter_snap, demo_if.count};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // acknowledge and read data; ack drops the cycle after it is given
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ack_ff <= 1'b0;
         rd_data_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= bus_req;
         if (bus_req && !wb_we_i) rd_data_ff <= rd_mux;
      end
   end
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rd_data_ff;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // gates clear LSB first over three cycles, then sleep
   sequence s_gates_off;
      (gate_en_ff == 16'hffc0) ##1 (gate_en_ff == 16'hf000) ##1
      (gate_en_ff == 16'h0000 && state_ff == ST_SLEEP);
   endsequence

   // gates set LSB first over three cycles, then buffer wait
   sequence s_gates_on;
      (gate_en_ff == 16'h003f) ##1 (gate_en_ff == 16'h0fff) ##1
      (gate_en_ff == 16'hffff && state_ff == ST_EXIT_BUF);
   endsequence

   a_enter_on_req: assert property (state_ff == ST_AWAKE && sleep_req |=> state_ff == ST_ENTER_BUF && status_ff)
      else $error("sleep request not taken");
   a_buf_off_step: assert property (state_ff == ST_ENTER_BUF && cnt_done |=> !buf_en_ff && state_ff == ST_ENTER_CLK)
      else $error("buffers not turned off after delay");
   a_gate_off_seq: assert property ($rose(state_ff == ST_ENTER_GATE) |=> s_gates_off)
      else $error("clock gates not cleared in order");
   a_sleep_hold: assert property (state_ff == ST_SLEEP && sleep_req |=> state_ff == ST_SLEEP && gate_en_ff == 16'h0000)
      else $error("left sleep while request held");
   a_exit_on_wake: assert property (state_ff == ST_SLEEP && !sleep_req |=> state_ff == ST_EXIT_CLK)
      else $error("wake-up not taken");
   a_gate_on_seq: assert property ($rose(state_ff == ST_EXIT_GATE) |=> s_gates_on)
      else $error("clock gates not set in order");
   a_buf_on_min: assert property ($rose(state_ff == ST_EXIT_BUF) |-> (!buf_en_ff && status_ff) [*8])
      else $error("buffers back on too early");
   a_buf_on_step: assert property (state_ff == ST_EXIT_BUF && cnt_done |=> buf_en_ff && !status_ff && state_ff == ST_AWAKE)
      else $error("buffers not restored after delay");
   a_awake_hold: assert property (state_ff == ST_AWAKE && !sleep_req |=> state_ff == ST_AWAKE && buf_en_ff)
      else $error("left awake without request");
   a_pads_float: assert property (!buf_drive_en |-> gpio_pad_oe == 4'h0 ##0 sleep_status)
      else $error("pads driven while buffers off");
   a_bus_ack_once: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("wishbone ack not a single cycle");
endmodule : slpseq_top

`default_nettype wire

/* File: tb_top.sv */
/*
 * self-checking bench for the sleep power sequencer;
 * assumes slpseq_top, its package and the far-side model are compiled first
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   logic sys_clk, resetn = 1'b0, want = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf, gpio_pad_o, gpio_pad_oe, pad_level;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [15:0] global_clock_net_en, net_ticks, ticks;
   logic buf_drive_en, sleep_status, sleep_req;
   logic [7:0] cnt_value, cnt_enter_snap, cnt_exit_snap, frozen;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;

   slpseq_top u_dut (.sys_clk(sys_clk), .resetn(resetn), .sleep_req(sleep_req),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .global_clock_net_en(global_clock_net_en), .buf_drive_en(buf_drive_en),
      .sleep_status(sleep_status), .gpio_pad_o(gpio_pad_o), .gpio_pad_oe(gpio_pad_oe),
      .cnt_value(cnt_value), .cnt_enter_snap(cnt_enter_snap),
      .cnt_exit_snap(cnt_exit_snap));
   slpseq_far_end u_far (.sys_clk(sys_clk), .resetn(resetn), .want_sleep(want),
      .global_clock_net_en(global_clock_net_en), .gpio_pad_o(gpio_pad_o),
      .gpio_pad_oe(gpio_pad_oe), .sleep_req(sleep_req), .pad_level(pad_level),
      .net_ticks(net_ticks));

   // 50 ns controller clock, free running
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // verdict and end of run, the only place the run stops
   task automatic report_and_stop();
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         report_and_stop();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // classic single wishbone cycle; waits for ack, bounded
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      chk("wb_ack_o", 32'(wb_ack_o), 32'h1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb

   // into sleep; a pulse drops the request right after it is taken
   task automatic enter(input int t1, input int t2, input bit pulse);
      @(posedge sys_clk);
      want <= 1'b1;
      @(posedge sys_clk);
      if (pulse) want <= 1'b0;
      #1 chk("sleep_status", 32'(sleep_status), 32'h1);
      chk("buf early", 32'(buf_drive_en), 32'h1);
      repeat (t1) @(posedge sys_clk);
      #1 chk("buf off", 32'(buf_drive_en), 32'h0);
      chk("pads", {gpio_pad_oe, pad_level}, 32'h0f);
      repeat (t2) @(posedge sys_clk);
      #1 chk("gates held", 32'(global_clock_net_en), 32'hffff);
      @(posedge sys_clk);
      #1 chk("gates 1", 32'(global_clock_net_en), 32'hffc0);
      @(posedge sys_clk);
      #1 chk("gates 2", 32'(global_clock_net_en), 32'hf000);
      @(posedge sys_clk);
      #1 chk("gates 3", 32'(global_clock_net_en), 32'h0000);
      frozen = cnt_value;
      ticks = net_ticks;
   endtask : enter

   // out of sleep; after a pulse the request is already low
   task automatic leave(input int t3, input int t4, input bit pulse);
      if (!pulse) begin
         repeat (4) @(posedge sys_clk);
         #1 chk("asleep", {global_clock_net_en, 15'h0, sleep_status}, 32'h1);
         @(posedge sys_clk);
         want <= 1'b0;
      end
      @(posedge sys_clk);
      repeat (t3) @(posedge sys_clk);
      #1 chk("gates wait", 32'(global_clock_net_en), 32'h0000);
      chk("frozen", 32'(cnt_value), 32'(frozen));
      chk("net ticks", 32'(net_ticks), 32'(ticks));
      @(posedge sys_clk);
      #1 chk("gates 1", 32'(global_clock_net_en), 32'h003f);
      @(posedge sys_clk);
      #1 chk("gates 2", 32'(global_clock_net_en), 32'h0fff);
      @(posedge sys_clk);
      #1 chk("gates 3", 32'(global_clock_net_en), 32'hffff);
      repeat (t4 - 1) @(posedge sys_clk);
      #1 chk("buf wait", {buf_drive_en, sleep_status}, 32'h1);
      @(posedge sys_clk);
      #1 chk("buf on", {gpio_pad_oe, buf_drive_en, sleep_status}, 32'h3e);
      chk("snaps", 32'(cnt_exit_snap), 32'(cnt_enter_snap));
      repeat (3) @(posedge sys_clk);
      #1 chk("awake", {cnt_value !== frozen, global_clock_net_en}, 32'h1ffff);
      chk("pad data", 32'(pad_level), 32'(8'(cnt_value - 8'h01) >> 4));
   endtask : leave

   initial begin
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      #1 chk("reset", {global_clock_net_en, gpio_pad_oe, buf_drive_en, sleep_status},
                 32'h003f_fffe);
      wb(1'b0, 4'h0, 32'h0, rd);
      chk("delay reset", rd, 32'h2801_0b01);
      wb(1'b0, 4'h4, 32'h0, rd);
      chk("status awake", rd, 32'hffff_0002);
      // least delays, then a repeat with larger programmed ones
      enter(1, 11, 1'b0);
      leave(1, 40, 1'b0);
      wb(1'b1, 4'h0, 32'h2d03_0005, rd);
      // single lane write: only the clock-off field may change
      wb_sel_i <= 4'h2;
      wb(1'b1, 4'h0, 32'h3f3f_143f, rd);
      wb_sel_i <= 4'hf;
      wb(1'b0, 4'h0, 32'h0, rd);
      chk("delay rw", rd, 32'h2d03_1405);
      wb(1'b0, 4'hc, 32'h0, rd);
      chk("unmapped", rd, 32'h0);
      enter(5, 20, 1'b0);
      wb(1'b0, 4'h4, 32'h0, rd);
      chk("status asleep", rd, 32'h9);
      wb(1'b0, 4'h8, 32'h0, rd);
      chk("count reg", rd, {8'h00, cnt_exit_snap, cnt_enter_snap, frozen});
      leave(3, 45, 1'b0);
      // zero settings act as the least delays; a short pulse still runs through
      wb(1'b1, 4'h0, 32'h0, rd);
      enter(1, 11, 1'b1);
      leave(1, 40, 1'b1);
      // second reset in mid-sequence
      @(posedge sys_clk);
      want <= 1'b1;
      @(posedge sys_clk);
      wb(1'b0, 4'h4, 32'h0, rd);
      chk("status entering", rd, 32'hffff_0005);
      resetn <= 1'b0;
      want <= 1'b0;
      @(posedge sys_clk);
      resetn <= 1'b1;
      #1 chk("re-reset", {global_clock_net_en, buf_drive_en, sleep_status}, 32'h3fffe);
      wb(1'b0, 4'h0, 32'h0, rd);
      chk("delay re-reset", rd, 32'h2801_0b01);
      report_and_stop();
   end
endmodule : tb_top

`default_nettype wire
